// >>> hdl/fanout_pkg.sv
// Shared constants for the clock fanout selector
package fanout_pkg;

  // Number of complementary output pairs
  localparam int OUTPUT_PAIRS = 22;

  // Depth of the pin input synchroniser
  localparam int SYNC_STAGES = 3;

  // Value of every synchroniser stage after reset
  localparam logic SYNC_RESET = 1'h0;

  // Output gate state after reset: outputs stopped
  localparam logic GATE_RESET = 1'h0;

  // True outputs after reset and while stopped
  localparam logic [OUTPUT_PAIRS-1:0] TRUE_RESET = 22'h000000;

  // Complementary outputs after reset and while stopped
  localparam logic [OUTPUT_PAIRS-1:0] COMP_RESET = 22'h3fffff;

  // Source select level that picks the emitter-coupled input
  localparam logic SELECT_ECL = 1'h1;

endpackage

// >>> hdl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pinIn,
  output logic levelOut
);

  // Synchroniser chain; the first stage feeds only the second
  logic [fanout_pkg::SYNC_STAGES-1:0] stage_reg;
  // Filtered level
  logic level_reg;

  // Shift the pin through the chain
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stage_reg <= {fanout_pkg::SYNC_STAGES{fanout_pkg::SYNC_RESET}};
    end else begin
      stage_reg <= {stage_reg[fanout_pkg::SYNC_STAGES-2:0], pinIn};
    end
  end

  // Accept a change once the second and third stages agree
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      level_reg <= fanout_pkg::SYNC_RESET;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level_reg <= stage_reg[2];
    end
  end

  assign levelOut = level_reg;

endmodule

// >>> hdl/glitchless_clock_fanout_mux.sv
// Two-input clock selector with synchronous enable and 22-pair fanout
//
// Functional notes
// - Selected clock copied onto all 22 pairs
// - Select low picks low-swing, high picks ECL
// - Enable changes only while outputs are low
// - Disabled: true outputs low, complements high
// - Enable takes effect synchronously, not immediately
// - Enable sampled at selected clock rising edge
// - Enable fall keeps outputs stopped from next cycle
// - Enable rise resumes toggling at next cycle
`timescale 1ns/1ps
module glitchless_clock_fanout_mux (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic lvdsClockIn,
  input wire logic eclClockIn,
  input wire logic sourceSelect,
  input wire logic outputEnable,
  output logic [fanout_pkg::OUTPUT_PAIRS-1:0] clockOutTrue,
  output logic [fanout_pkg::OUTPUT_PAIRS-1:0] clockOutComp
);

  // Synchronised copies of the four pins
  logic lvdsSync;
  logic eclSync;
  logic selectSync;
  logic enableSync;

  // Currently selected input clock level
  logic selClock;
  // Selected clock one cycle earlier, for edge detection
  logic selClockPrev_reg;
  // One-cycle pulse on a rising edge of the selected clock
  logic risingEdge;

  // Output gate: high while outputs are allowed to toggle
  logic gate_reg;
  logic gate_next;

  // Registered output pairs
  logic [fanout_pkg::OUTPUT_PAIRS-1:0] true_reg;
  logic [fanout_pkg::OUTPUT_PAIRS-1:0] comp_reg;
  logic [fanout_pkg::OUTPUT_PAIRS-1:0] true_next;

  // Low-swing clock input synchroniser
  pin_sync lvdsSyncInst (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn(lvdsClockIn),
    .levelOut(lvdsSync)
  );

  // Emitter-coupled clock input synchroniser
  pin_sync eclSyncInst (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn(eclClockIn),
    .levelOut(eclSync)
  );

  // Source select pin synchroniser
  pin_sync selectSyncInst (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn(sourceSelect),
    .levelOut(selectSync)
  );

  // Enable pin synchroniser; the pin may change at any time
  pin_sync enableSyncInst (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn(outputEnable),
    .levelOut(enableSync)
  );

  // Pick the input clock from the select level
  always_comb begin
    if (selectSync == fanout_pkg::SELECT_ECL) begin
      selClock = eclSync;
    end else begin
      selClock = lvdsSync;
    end
  end

  // Remember the selected clock to find its rising edges
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      selClockPrev_reg <= fanout_pkg::SYNC_RESET;
    end else begin
      selClockPrev_reg <= selClock;
    end
  end

  // Rising edge of the selected clock
  assign risingEdge = selClock & ~selClockPrev_reg;

  // Sample the enable only at a rising edge; hold it otherwise
  always_comb begin
    if (risingEdge) begin
      gate_next = enableSync;
    end else begin
      gate_next = gate_reg;
    end
  end

  // Gate register; it switches only as a low phase ends
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gate_reg <= fanout_pkg::GATE_RESET;
    end else begin
      gate_reg <= gate_next;
    end
  end

  // Gated clock copied onto every true output
  assign true_next = {fanout_pkg::OUTPUT_PAIRS{gate_next & selClock}};

  // Output pair registers; complement is always the inverse
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      true_reg <= fanout_pkg::TRUE_RESET;
      comp_reg <= fanout_pkg::COMP_RESET;
    end else begin
      true_reg <= true_next;
      comp_reg <= ~true_next;
    end
  end

  // Drive the pins from the registers
  assign clockOutTrue = true_reg;
  assign clockOutComp = comp_reg;

  // Checks run on the reference clock, idle during reset
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Every pair carries the same waveform
  property p_fanout_equal;
    clockOutTrue == {fanout_pkg::OUTPUT_PAIRS{clockOutTrue[0]}};
  endproperty
  a_fanout_equal: assert property (p_fanout_equal)
    else $error("Output pairs disagree");

  // With high select and gate open, outputs follow the ECL input
  property p_route_ecl;
    (gate_next && selectSync) |=> (clockOutTrue[0] == $past(eclSync));
  endproperty
  a_route_ecl: assert property (p_route_ecl)
    else $error("ECL input not routed");

  // With low select and gate open, outputs follow the low-swing input
  property p_route_lvds;
    (gate_next && !selectSync) |=> (clockOutTrue[0] == $past(lvdsSync));
  endproperty
  a_route_lvds: assert property (p_route_lvds)
    else $error("Low-swing input not routed");

  // The gate moves only when the outputs were low
  property p_no_runt;
    $changed(gate_reg) |-> ($past(clockOutTrue[0]) == 1'b0);
  endproperty
  a_no_runt: assert property (p_no_runt)
    else $error("Gate changed during high phase");

  // Stopped outputs: true low, complement high
  property p_disabled_level;
    !gate_reg |-> (clockOutTrue == fanout_pkg::TRUE_RESET &&
                   clockOutComp == fanout_pkg::COMP_RESET);
  endproperty
  a_disabled_level: assert property (p_disabled_level)
    else $error("Disabled outputs at wrong level");

  // Enable seen at an edge opens the gate next cycle
  property p_enable_sync;
    (risingEdge && enableSync) |=> gate_reg;
  endproperty
  a_enable_sync: assert property (p_enable_sync)
    else $error("Enable not taken at edge");

  // Without an edge the gate holds, whatever the pin does
  property p_sample_point;
    !risingEdge |=> $stable(gate_reg);
  endproperty
  a_sample_point: assert property (p_sample_point)
    else $error("Gate moved between edges");

  // Enable low at an edge keeps the gate shut and outputs low for the next two cycles
  property p_stop;
    (risingEdge && !enableSync) |=> (!gate_reg && !clockOutTrue[0]) [*2];
  endproperty
  a_stop: assert property (p_stop)
    else $error("Outputs not held stopped");

  // Enable high at an edge starts a full high phase at once
  property p_start;
    (risingEdge && enableSync) |=> clockOutTrue[0];
  endproperty
  a_start: assert property (p_start)
    else $error("Outputs did not resume");

  // Opening the gate always begins a fresh high phase, never a partial one
  property p_open_high;
    $rose(gate_reg) |-> $rose(clockOutTrue[0]);
  endproperty
  a_open_high: assert property (p_open_high)
    else $error("Gate opened without a full high phase");

  // Complement is always the inverse of the true output
  property p_complement;
    clockOutComp == ~clockOutTrue;
  endproperty
  a_complement: assert property (p_complement)
    else $error("Complement not inverse");

  // Scenario coverage
  c_enable_rise: cover property ($rose(gate_reg));
  c_enable_fall: cover property ($fell(gate_reg));
  c_source_switch: cover property (gate_reg && $changed(selectSync));
  // Enable pin already low while the gate waits for the next rising edge
  c_enable_pending: cover property (gate_reg && !enableSync);
  c_toggle: cover property (gate_reg && $rose(clockOutTrue[0]) ##[1:8] $fell(clockOutTrue[0]));

endmodule

// >>> verif/clock_source_model.sv
// Behavioural input clock sources feeding the fanout selector
`timescale 1ns/1ps
module clock_source_model (
  input wire logic lvdsRun,
  input wire logic eclRun,
  output logic lvdsClockIn,
  output logic eclClockIn
);
  // Low-swing source, odd half period keeps it out of phase with ref_clk
  initial begin
    lvdsClockIn = 1'h0;
    forever begin
      #203;
      // A stopped source simply holds its level
      if (lvdsRun) begin
        lvdsClockIn = ~lvdsClockIn;
      end
    end
  end
  // Emitter-coupled source, slower than the low-swing one
  initial begin
    eclClockIn = 1'h0;
    forever begin
      #307;
      if (eclRun) begin
        eclClockIn = ~eclClockIn;
      end
    end
  end
endmodule

// >>> verif/glitchless_clock_fanout_mux_tb.sv
// Self-checking bench for the clock fanout selector
`timescale 1ns/1ps
module glitchless_clock_fanout_mux_tb;
  logic ref_clk, reset_n, sourceSelect, outputEnable, lvdsRun, eclRun, watchRunt;
  logic lvdsClockIn, eclClockIn;
  logic [fanout_pkg::OUTPUT_PAIRS-1:0] clockOutTrue, clockOutComp;
  int fail_count = 0;
  int comparisons = 0;
  int runLen = 0;
  int riseCount = 0;
  logic lastTrue = 1'h0;
  // Sampling clock, 25 ns period
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  clock_source_model src_u (.lvdsRun(lvdsRun), .eclRun(eclRun),
    .lvdsClockIn(lvdsClockIn), .eclClockIn(eclClockIn));
  glitchless_clock_fanout_mux dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .lvdsClockIn(lvdsClockIn), .eclClockIn(eclClockIn), .sourceSelect(sourceSelect),
    .outputEnable(outputEnable), .clockOutTrue(clockOutTrue), .clockOutComp(clockOutComp));
  // Compares one vector result and counts it
  task automatic check_vec(input string name, input logic [21:0] expVal,
    input logic [21:0] gotVal);
    comparisons++;
    if (gotVal !== expVal) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, expVal, gotVal);
    end
  endtask
  // Prints the counts and the verdict
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Pairing every cycle; rise count at each output change, phase length there too only while watchRunt is set
  always @(negedge ref_clk) begin
    if (reset_n) begin
      check_vec("comp", ~clockOutTrue, clockOutComp);
      check_vec("fanout", {fanout_pkg::OUTPUT_PAIRS{clockOutTrue[0]}}, clockOutTrue);
      runLen++;
      if (clockOutTrue[0] !== lastTrue) begin
        if (watchRunt) check_vec("phase", 22'h1, {21'h0, runLen > 5});
        if (clockOutTrue[0]) riseCount++;
        runLen = 0;
      end
      lastTrue = clockOutTrue[0];
    end
  end
  // Enable raised just after the selected input rises: it must wait for the next rise
  task automatic enable_rise();
    @(posedge lvdsClockIn);
    @(posedge ref_clk);
    @(negedge ref_clk);
    outputEnable = 1'h1;
    repeat (8) begin
      @(negedge ref_clk);
      check_vec("early", fanout_pkg::TRUE_RESET, clockOutTrue);
    end
    riseCount = 0;
    wait_cyc(40);
    check_vec("started", 22'h1, {21'h0, riseCount > 0});
  endtask
  // Picks a source with only some inputs running and counts output rises
  task automatic run_source(input logic sel, input logic lvds, input logic ecl,
    input logic moves);
    watchRunt = 1'h0;
    sourceSelect = sel;
    lvdsRun = lvds;
    eclRun = ecl;
    wait_cyc(30);
    watchRunt = 1'h1;
    riseCount = 0;
    wait_cyc(300);
    check_vec("route", {21'h0, moves}, {21'h0, riseCount > 6});
  endtask
  // Disable and expect the stopped levels to hold
  task automatic disable_out();
    outputEnable = 1'h0;
    wait_cyc(40);
    repeat (40) begin
      @(negedge ref_clk);
      check_vec("stopTrue", fanout_pkg::TRUE_RESET, clockOutTrue);
      check_vec("stopComp", fanout_pkg::COMP_RESET, clockOutComp);
    end
  endtask
  // Hang guard, well above the expected run length
  initial begin
    repeat (4000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    reset_n = 1'h0;
    sourceSelect = 1'h0;
    outputEnable = 1'h0;
    lvdsRun = 1'h1;
    eclRun = 1'h0;
    watchRunt = 1'h1;
    wait_cyc(8);
    check_vec("rstTrue", fanout_pkg::TRUE_RESET, clockOutTrue);
    check_vec("rstComp", fanout_pkg::COMP_RESET, clockOutComp);
    reset_n = 1'h1;
    wait_cyc(40);
    enable_rise();
    run_source(1'h0, 1'h1, 1'h0, 1'h1);
    run_source(1'h0, 1'h0, 1'h1, 1'h0);
    run_source(1'h1, 1'h0, 1'h1, 1'h1);
    run_source(1'h1, 1'h1, 1'h0, 1'h0);
    run_source(1'h1, 1'h0, 1'h1, 1'h1);
    disable_out();
    finish_test();
  end
endmodule
